// file: inc/cam_pkg.sv
package cam_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned CH_W      = 3;
  localparam int unsigned AXIS_W    = 8;
  localparam int unsigned SLOT_W    = 8;
  localparam int unsigned POINT_W   = 6;
  localparam int unsigned MAX_PTS   = 32;
  localparam int unsigned EXP_SLOTS = 4;
  localparam int unsigned EXP_BITS  = EXP_SLOTS * MAX_PTS;

  // ---------------------------------------------------------------
  // Slot codes
  // ---------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_NONE      = 8'h00;
  localparam logic [SLOT_W-1:0] SLOT_EXP_LO    = 8'h04;
  localparam logic [SLOT_W-1:0] SLOT_EXP_HI    = 8'h07;
  localparam logic [SLOT_W-1:0] SLOT_OWN_DRIVE = 8'h64;
  localparam logic [SLOT_W-1:0] SLOT_DRIVE_HI  = 8'hE8;
  localparam logic [POINT_W-1:0] POINT_FIRST   = 6'h01;
  localparam logic [POINT_W-1:0] POINT_LAST    = 6'h20;

  // ---------------------------------------------------------------
  // Setpoint range in feedback counts (-536870912 .. 536870911)
  // ---------------------------------------------------------------
  localparam logic signed [31:0] SETPT_MIN = 32'shE0000000;
  localparam logic signed [31:0] SETPT_MAX = 32'sh1FFFFFFF;

  // ---------------------------------------------------------------
  // Register map: channel n at 0x10*n, global state word at 0x80
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_ON     = 4'h0;
  localparam logic [3:0] OFS_OFF    = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_STAT   = 4'hC;
  localparam logic [7:0] ADDR_STATE = 8'h80;

  localparam int unsigned CTRL_AXIS_LSB  = 0;
  localparam int unsigned CTRL_SLOT_LSB  = 8;
  localparam int unsigned CTRL_POINT_LSB = 16;
  localparam int unsigned CTRL_DIS_BIT   = 24;
  localparam int unsigned STAT_OK_BIT    = 0;
  localparam int unsigned STAT_STATE_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] RDATA_RST    = 32'h00000000;
  localparam logic [1:0]  RD_WAIT_LAST = 2'h2;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic        HRESP_OKAY   = 1'b0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                channel_disable;
    logic [POINT_W-1:0]  output_point_index;
    logic [SLOT_W-1:0]   slot;
    logic [AXIS_W-1:0]   axis;
  } cam_ctrl_t;

  localparam cam_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic                valid;
    logic [AXIS_W-1:0]   axis;
    logic [POINT_W-1:0]  output_point_index;
    logic                level;
  } drive_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       low_page;
    logic [7:0] addr;
  } bus_phase_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FETCH,
    SEQ_WAIT,
    SEQ_EVAL
  } seq_state_t;

endpackage : cam_pkg

// file: rtl/cam_setpoint_mem.sv
`timescale 1ns/1ps
`default_nettype none

module cam_setpoint_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          arst_n_i,
  // Write port, one half word per enable bit
  input  wire logic [1:0]    we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [31:0]   wdata_i,
  // Read port A
  input  wire logic          ra_en_i,
  input  wire logic [AW-1:0] ra_addr_i,
  output logic [63:0]        ra_data_o,
  // Read port B
  input  wire logic          rb_en_i,
  input  wire logic [AW-1:0] rb_addr_i,
  output logic [63:0]        rb_data_o
);

  logic [63:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (we_i[0]) begin
      mem_q[waddr_i][31:0] <= wdata_i;
    end
    if (we_i[1]) begin
      mem_q[waddr_i][63:32] <= wdata_i;
    end
  end

  // Read data hold until the next enabled read
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ra_data_o <= '0;
      rb_data_o <= '0;
    end else begin
      if (ra_en_i) begin
        ra_data_o <= mem_q[ra_addr_i];
      end
      if (rb_en_i) begin
        rb_data_o <= mem_q[rb_addr_i];
      end
    end
  end

endmodule : cam_setpoint_mem

`default_nettype wire

// file: rtl/cam_position_switch.sv
// Contract
// - Every configured cam point is recomputed once per servo tick.
// - With on above off the active window wraps through rollover.
// - An out-of-range on or off setpoint is refused and ok stays low.
// - Slot 0 drives no physical point, only the switch state.
// - A disabled channel holds outputs low and is skipped per tick.
// - Equal on and off gives no output but is still evaluated.
// - Slot 100 drives the digital drive of the channel's own axis.
// - Slots 101 to 232 drive the digital drive of axis code-100.
// - Slots 4 to 7 select an expansion output module.
// - Each channel shows its logical window state as switch state.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module cam_position_switch
  import cam_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic [31:0]               hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // Servo tick pin
  input  wire logic                 servo_tick_i,
  // Axis position source
  output logic                      pos_req_o,
  output logic [AXIS_W-1:0]         pos_axis_o,
  input  wire logic signed [31:0]   pos_value_i,
  input  wire logic signed [31:0]   pos_rollover_i,
  // Cam results
  output logic [NUM_CH-1:0]         switch_state_o,
  output logic [EXP_BITS-1:0]       exp_out_o,
  output drive_cmd_t                drive_cmd_o
);

  // ---------------------------------------------------------------
  // Tick synchroniser and edge detect
  // ---------------------------------------------------------------
  logic tick_meta_q, tick_sync_q, tick_prev_q;
  wire  tick_rise = tick_sync_q & ~tick_prev_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_meta_q <= 1'b0;
      tick_sync_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      tick_meta_q <= servo_tick_i;
      tick_sync_q <= tick_meta_q;
      tick_prev_q <= tick_sync_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus phase tracking
  // ---------------------------------------------------------------
  bus_phase_t  dp_q, dp_d;
  logic [1:0]  rd_cnt_q, rd_cnt_d;
  logic [31:0] hrdata_q, hrdata_d;

  wire take     = hsel_i & htrans_i[1] & hready_i;
  wire dp_write = dp_q.valid & dp_q.write;
  wire dp_read  = dp_q.valid & ~dp_q.write;
  wire rd_done  = dp_read & (rd_cnt_q == RD_WAIT_LAST);

  // Reads wait two cycles so a write just before is always seen
  assign hreadyout_o = ~dp_read | rd_done;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = hrdata_q;

  wire [CH_W-1:0] a_ch    = dp_q.addr[CH_W+3:4];
  wire [3:0]      a_ofs   = dp_q.addr[3:0];
  wire            a_chan  = dp_q.low_page & ~dp_q.addr[7];
  wire            a_state = dp_q.low_page & (dp_q.addr == ADDR_STATE);

  wire wr_on   = dp_write & a_chan & (a_ofs == OFS_ON);
  wire wr_off  = dp_write & a_chan & (a_ofs == OFS_OFF);
  wire wr_ctrl = dp_write & a_chan & (a_ofs == OFS_CTRL);

  wire setpt_ok = ($signed(hwdata_i) >= SETPT_MIN) &&
                  ($signed(hwdata_i) <= SETPT_MAX);

  always_comb begin
    dp_d = dp_q;
    if (hreadyout_o) begin
      dp_d.valid    = take;
      dp_d.write    = hwrite_i;
      dp_d.low_page = (haddr_i[31:8] == 24'h000000);
      dp_d.addr     = haddr_i[7:0];
    end
  end

  assign rd_cnt_d = (dp_read && !rd_done) ? rd_cnt_q + 2'h1 : 2'h0;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp_q     <= '0;
      rd_cnt_q <= 2'h0;
      hrdata_q <= RDATA_RST;
    end else begin
      dp_q     <= dp_d;
      rd_cnt_q <= rd_cnt_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Channel configuration and setpoint flags
  // ---------------------------------------------------------------
  cam_ctrl_t         ctrl_q [NUM_CH];
  logic [NUM_CH-1:0] on_ok_q, off_ok_q;
  logic [NUM_CH-1:0] state_q, state_d;
  logic [NUM_CH-1:0] drive_on_q, drive_on_d;
  logic [NUM_CH-1:0] clr_mask;
  logic [EXP_BITS-1:0] img [NUM_CH+1];

  assign img[0] = '0;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire sel = (a_ch == CH_W'(g));
      wire cam_ctrl_t c = ctrl_q[g];
      wire exp_hit = (c.slot >= SLOT_EXP_LO) && (c.slot <= SLOT_EXP_HI) &&
                     (c.output_point_index >= POINT_FIRST) &&
                     (c.output_point_index <= POINT_LAST) &&
                     !c.channel_disable && state_q[g];
      wire [7:0] bit_idx = {c.slot[1:0], 6'h00} >> 1;
      wire [7:0] pos_idx = bit_idx +
                           {2'h0, c.output_point_index} - 8'h01;
      assign img[g+1] = img[g] |
        (exp_hit ? (EXP_BITS'(1) << pos_idx) : '0);

      // disable or refusal clears the state at once
      assign clr_mask[g] = sel & ((wr_ctrl & hwdata_i[CTRL_DIS_BIT]) |
                                  ((wr_on | wr_off) & ~setpt_ok));

      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ctrl_q[g]   <= CTRL_RST;
          on_ok_q[g]  <= 1'b0;
          off_ok_q[g] <= 1'b0;
        end else begin
          if (wr_ctrl && sel) begin
            ctrl_q[g] <= {hwdata_i[CTRL_DIS_BIT],
                          hwdata_i[CTRL_POINT_LSB +: POINT_W],
                          hwdata_i[CTRL_SLOT_LSB +: SLOT_W],
                          hwdata_i[CTRL_AXIS_LSB +: AXIS_W]};
          end
          if (wr_on && sel) begin
            on_ok_q[g] <= setpt_ok;
          end
          if (wr_off && sel) begin
            off_ok_q[g] <= setpt_ok;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Setpoint memory: {on, off} per channel
  // ---------------------------------------------------------------
  logic [63:0] bus_rd, seq_rd;
  wire  [1:0]  mem_we = {wr_on & setpt_ok, wr_off & setpt_ok};
  wire         bus_re = dp_read & (rd_cnt_q == 2'h0);
  seq_state_t  seq_q, seq_d;
  logic [CH_W-1:0] ch_q, ch_d;

  cam_setpoint_mem #(
    .DEPTH (NUM_CH),
    .AW    (CH_W)
  ) u_mem (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .we_i      (mem_we),
    .waddr_i   (a_ch),
    .wdata_i   (hwdata_i),
    .ra_en_i   (bus_re),
    .ra_addr_i (a_ch),
    .ra_data_o (bus_rd),
    .rb_en_i   (seq_q == SEQ_FETCH),
    .rb_addr_i (ch_q),
    .rb_data_o (seq_rd)
  );

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  cam_ctrl_t rc;
  assign rc = ctrl_q[a_ch];

  wire [31:0] ctrl_word =
    (32'(rc.channel_disable) << CTRL_DIS_BIT) |
    (32'(rc.output_point_index) << CTRL_POINT_LSB) |
    (32'(rc.slot) << CTRL_SLOT_LSB) |
    (32'(rc.axis) << CTRL_AXIS_LSB);
  wire [31:0] stat_word =
    (32'(on_ok_q[a_ch] & off_ok_q[a_ch]) << STAT_OK_BIT) |
    (32'(state_q[a_ch]) << STAT_STATE_BIT);

  always_comb begin
    hrdata_d = hrdata_q;
    if (dp_read && rd_cnt_q == 2'h1) begin
      hrdata_d = RDATA_RST;
      if (a_state) begin
        hrdata_d = 32'(state_q);
      end else if (a_chan) begin
        case (a_ofs)
          OFS_ON:   hrdata_d = bus_rd[63:32];
          OFS_OFF:  hrdata_d = bus_rd[31:0];
          OFS_CTRL: hrdata_d = ctrl_word;
          OFS_STAT: hrdata_d = stat_word;
          default:  hrdata_d = RDATA_RST;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-tick sweep over the channels
  // ---------------------------------------------------------------
  cam_ctrl_t sc;
  assign sc = ctrl_q[ch_q];

  // skip disabled channels; refused setpoints also skip
  wire skip    = sc.channel_disable | ~(on_ok_q[ch_q] & off_ok_q[ch_q]);
  wire last_ch = (ch_q == CH_W'(NUM_CH - 1));

  // Position taken within its rollover cycle, one correction step
  wire signed [31:0] p_raw = pos_value_i;
  wire signed [31:0] p_cyc =
    (p_raw < 0) ? p_raw + pos_rollover_i :
    (p_raw >= pos_rollover_i) ? p_raw - pos_rollover_i : p_raw;

  wire signed [31:0] on_v  = seq_rd[63:32];
  wire signed [31:0] off_v = seq_rd[31:0];
  wire ge_on  = p_cyc >= on_v;
  wire lt_off = p_cyc < off_v;
  // wrapped window when on exceeds off
  // inclusive at on, exclusive at off
  wire win = (on_v == off_v) ? 1'b0 :
             (on_v < off_v) ? (ge_on & lt_off) : (ge_on | lt_off);

  wire is_drive  = (sc.slot >= SLOT_OWN_DRIVE) && (sc.slot <= SLOT_DRIVE_HI);
  wire [AXIS_W-1:0] drv_axis =
    (sc.slot == SLOT_OWN_DRIVE) ? sc.axis : sc.slot - SLOT_OWN_DRIVE;

  logic             pos_req_d;
  logic [AXIS_W-1:0] pos_axis_d;
  drive_cmd_t       drv_d, drv_q;

  always_comb begin
    seq_d      = seq_q;
    ch_d       = ch_q;
    state_d    = state_q;
    drive_on_d = drive_on_q;
    pos_req_d  = 1'b0;
    pos_axis_d = pos_axis_o;
    drv_d      = drv_q;
    drv_d.valid = 1'b0;
    case (seq_q)
      SEQ_IDLE: begin
        if (tick_rise) begin
          seq_d = SEQ_FETCH;
          ch_d  = '0;
        end
      end
      SEQ_FETCH: begin
        if (skip) begin
          // Release a drive point left on before the disable
          if (sc.channel_disable && drive_on_q[ch_q]) begin
            drv_d      = '{1'b1, drv_axis, sc.output_point_index, 1'b0};
            drive_on_d[ch_q] = 1'b0;
          end
          seq_d = last_ch ? SEQ_IDLE : SEQ_FETCH;
          ch_d  = ch_q + CH_W'(1);
        end else begin
          pos_req_d  = 1'b1;
          pos_axis_d = sc.axis;
          seq_d      = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        seq_d = SEQ_EVAL;
      end
      SEQ_EVAL: begin
        // logical state; a disable landing mid-fetch wins
        state_d[ch_q] = win & ~skip;
        // slot 0 and other codes drive nothing
        if (is_drive && !skip) begin
          drv_d = '{1'b1, drv_axis, sc.output_point_index, win};
          drive_on_d[ch_q] = win;
        end
        seq_d = last_ch ? SEQ_IDLE : SEQ_FETCH;
        ch_d  = ch_q + CH_W'(1);
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
    // a disabling write wins over a concurrent evaluation
    state_d = state_d & ~clr_mask;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_q      <= SEQ_IDLE;
      ch_q       <= '0;
      state_q    <= '0;
      drive_on_q <= '0;
      pos_req_o  <= 1'b0;
      pos_axis_o <= '0;
      drv_q      <= '0;
      exp_out_o  <= '0;
    end else begin
      seq_q      <= seq_d;
      ch_q       <= ch_d;
      state_q    <= state_d;
      drive_on_q <= drive_on_d;
      pos_req_o  <= pos_req_d;
      pos_axis_o <= pos_axis_d;
      drv_q      <= drv_d;
      exp_out_o  <= img[NUM_CH];
    end
  end

  assign switch_state_o = state_q;
  assign drive_cmd_o    = drv_q;

endmodule : cam_position_switch

`default_nettype wire

// file: tb/cam_position_switch_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module cam_position_switch_chk
  import cam_pkg::*;
(
  // Bus side
  input wire logic                sys_clk_i,
  input wire logic                arst_n_i,
  input wire logic                hsel_i,
  input wire logic [1:0]          htrans_i,
  input wire logic                hwrite_i,
  input wire logic                hready_i,
  input wire logic [31:0]         hrdata_o,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o,
  // Sweep side
  input wire logic                servo_tick_i,
  input wire logic                pos_req_o,
  input wire logic [AXIS_W-1:0]   pos_axis_o,
  input wire logic [NUM_CH-1:0]   switch_state_o,
  input wire logic [EXP_BITS-1:0] exp_out_o,
  input wire drive_cmd_t          drive_cmd_o
);
  logic       taken;
  logic       rd_dp_q;
  logic       wr_dp_q;
  logic [2:0] tick_q;
  logic [4:0] nreq_q;

  assign taken = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_dp_q <= 1'b0;
      wr_dp_q <= 1'b0;
      tick_q  <= 3'h0;
      nreq_q  <= 5'h00;
    end else begin
      rd_dp_q <= taken ? !hwrite_i : rd_dp_q && !hreadyout_o;
      wr_dp_q <= taken && hwrite_i;
      tick_q  <= {tick_q[1:0], servo_tick_i};
      // Restart the count near the tick edge, before the sweep begins
      nreq_q  <= (tick_q[1] && !tick_q[2]) ? 5'h00 : nreq_q + 5'(pos_req_o);
    end
  end

  // ------------
  // Assertions
  // ------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_resp_okay: assert property (hresp_o == HRESP_OKAY)
    else $error("response not OKAY");
  a_read_wait: assert property (taken && !hwrite_i |=>
    !hreadyout_o [*2] ##1 hreadyout_o)
    else $error("read wait count wrong");
  a_write_ready: assert property (taken && hwrite_i |=> hreadyout_o)
    else $error("write not zero wait");
  a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(rd_dp_q))
    else $error("read data moved outside a read");
  a_req_pulse: assert property (pos_req_o |=> !pos_req_o)
    else $error("position request too long");
  a_axis_hold: assert property (pos_req_o |=> $stable(pos_axis_o) [*2])
    else $error("axis moved during fetch");
  a_req_count: assert property (nreq_q <= 5'(NUM_CH))
    else $error("too many requests in one tick");
  a_state_cause: assert property ($changed(switch_state_o) |->
    $past(pos_req_o, 2) || $past(wr_dp_q) || $past(wr_dp_q, 2))
    else $error("switch state changed without cause");

  c_read: cover property (taken && !hwrite_i);
  c_fetch: cover property (pos_req_o);
  c_drive: cover property (drive_cmd_o.valid);
  c_exp: cover property (exp_out_o != '0);
endmodule : cam_position_switch_chk

`default_nettype wire

// file: tb/cam_pos_source.sv
`timescale 1ns/1ps
`default_nettype none

module cam_pos_source (
  // Clock and request
  input  wire logic               sys_clk_i,
  input  wire logic               pos_req_i,
  // Position and cycle the bench sets
  input  wire logic signed [31:0] pos_set_i,
  input  wire logic signed [31:0] roll_i,
  // Answer to the block
  output logic signed [31:0]      pos_value_o,
  output logic signed [31:0]      pos_rollover_o
);
  logic               vld_q = 1'b0;
  logic signed [31:0] pos_q = '0;
  logic signed [31:0] roll_q = '0;

  always @(posedge sys_clk_i) begin
    vld_q <= pos_req_i;
    if (pos_req_i) begin
      pos_q  <= pos_set_i;
      roll_q <= roll_i;
    end
  end

  // rollover inverted the same way
  // Outside the answer cycle show the inverse, so stale data cannot pass
  assign pos_value_o    = vld_q ? pos_q : ~pos_q;
  assign pos_rollover_o = vld_q ? roll_q : ~roll_q;
endmodule : cam_pos_source

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cam_pkg::*;
;
  localparam int ROLL = 1000;

  logic                sys_clk_i = 1'b0;
  logic                arst_n_i = 1'b0;
  logic [31:0]         haddr = '0;
  logic [1:0]          htrans = '0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = '0;
  logic                tick = 1'b0;
  logic                rd_ph = 1'b0;
  logic signed [31:0]  pos_set = '0;
  logic [31:0]         hrdata;
  logic                hready;
  logic                pos_req;
  logic [AXIS_W-1:0]   pos_axis;
  logic signed [31:0]  pos_value;
  logic signed [31:0]  pos_roll;
  logic [NUM_CH-1:0]   state;
  logic [EXP_BITS-1:0] exp_out;
  drive_cmd_t          drive;
  int                  miscompares = 0;
  int                  total_checks = 0;
  int                  seed = 63;
  logic [31:0]         rq[$];
  logic [14:0]         dq[$];
  logic [7:0]          aq[$];
  int                  on_a[8] = '{100, 200, 300, 0, 0, 400, 600, 100};
  int                  off_a[8] = '{200, 100, 300, 999, 500, 600, 50, 200};
  int                  pl[5] = '{100, 199, 200, 99, -1};
  // valid selections, unique points on slot 4
  logic [31:0]         ctl_a[8] = '{32'h00010401, 32'h00020001,
    32'h00030001, 32'h01030401, 32'h00040002, 32'h00020007,
    32'h00040003, 32'h00050001};

  always #4 sys_clk_i = ~sys_clk_i;

  cam_position_switch i_cam_position_switch (
    .sys_clk_i, .arst_n_i, .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .servo_tick_i(tick),
    .pos_req_o(pos_req), .pos_axis_o(pos_axis), .pos_value_i(pos_value),
    .pos_rollover_i(pos_roll), .switch_state_o(state),
    .exp_out_o(exp_out), .drive_cmd_o(drive));

  cam_pos_source i_cam_pos_source (
    .sys_clk_i, .pos_req_i(pos_req), .pos_set_i(pos_set),
    .roll_i(ROLL), .pos_value_o(pos_value), .pos_rollover_o(pos_roll));

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, act, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [31:0] act, input logic [31:0] exp);
    chk(act, exp);
  endtask : chk_rd

  task automatic chk_drv(input logic [14:0] act, input logic [14:0] exp);
    chk({17'h0, act}, {17'h0, exp});
  endtask : chk_drv

  task automatic chk_axis(input logic [7:0] act, input logic [7:0] exp);
    chk({24'h0, act}, {24'h0, exp});
  endtask : chk_axis

  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask : hold

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    htrans <= HTRANS_NSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hold();
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= !w;
    hold();
    rd_ph  <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic win(input int on, input int off, input int p);
    if (p < 0) p += ROLL;
    if (p >= ROLL) p -= ROLL;
    if (on < off) return p >= on && p < off;
    if (on > off) return p >= on || p < off;
    return 1'b0;
  endfunction : win

  task automatic sweep(input int p, input logic ph2);
    logic [7:0] st;
    st = '0;
    for (int k = 0; k < 7; k++) begin
      st[k] = (k != 3) && win(on_a[k], off_a[k], p);
      if (k != 3) aq.push_back(ctl_a[k][7:0]);
    end
    if (ph2) begin
      dq.push_back({8'h01, 6'h02, st[5]});
      dq.push_back({8'h03, 6'h04, st[6]});
    end
    @(posedge sys_clk_i);
    pos_set <= p;
    tick    <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    tick    <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    chk({24'h0, state}, {24'h0, st});
    rd(ADDR_STATE, {24'h0, st});
    chk(exp_out[31:0], {31'h0, st[0] & !ph2});
    chk(32'(|exp_out[EXP_BITS-1:32]), 32'h0);
  endtask : sweep

  always @(posedge sys_clk_i) begin
    if (rd_ph && hready === 1'b1) chk_rd(hrdata, rq.pop_front());
    if (drive.valid === 1'b1) begin
      chk_drv(drive[14:0], dq.pop_front());
    end
    if (pos_req === 1'b1) begin
      chk_axis(pos_axis, aq.pop_front());
    end
  end

  initial begin
    int c;
    int p;
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_STATE, 32'h0);
    rd({4'h5, OFS_CTRL}, 32'h0);
    bus(1'b1, 8'h90, 32'hFFFFFFFF);
    rd(8'h90, 32'h0);
    $display("reset test done");
    for (c = 0; c < 8; c++) begin
      bus(1'b1, {c[3:0], OFS_ON}, (c == 7) ? 32'h20000000 : on_a[c]);
      bus(1'b1, {c[3:0], OFS_OFF}, (c == 7) ? 32'hDFFFFFFF : off_a[c]);
      bus(1'b1, {c[3:0], OFS_CTRL}, ctl_a[c]);
    end
    rd({4'h5, OFS_CTRL}, ctl_a[5]);
    rd({4'h0, OFS_STAT}, 32'h1);
    rd({4'h7, OFS_STAT}, 32'h0);
    $display("config test done");
    for (c = 0; c < 10; c++) begin
      if (c == 5) begin
        bus(1'b1, {4'h0, OFS_CTRL}, 32'h00010001);
        bus(1'b1, {4'h3, OFS_CTRL}, 32'h01030001);
        bus(1'b1, {4'h5, OFS_CTRL}, 32'h00026507);
        bus(1'b1, {4'h6, OFS_CTRL}, 32'h00046403);
      end
      p = (c < 5) ? pl[c] : $unsigned($random(seed)) % ROLL;
      sweep(p, c >= 5);
      $display("sweep %0d done", c);
    end
    chk(32'(dq.size()), 32'h0);
    chk(32'(aq.size()), 32'h0);
    bus(1'b1, {4'h5, OFS_ON}, 32'h20000000);
    rd({4'h5, OFS_STAT}, 32'h0);
    results();
  end
endmodule : tb_top

bind cam_position_switch cam_position_switch_chk i_cam_position_switch_chk (
  .sys_clk_i, .arst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .servo_tick_i, .pos_req_o,
  .pos_axis_o, .switch_state_o, .exp_out_o, .drive_cmd_o);

`default_nettype wire
